// file: hw/fault_code_cell.sv
/*
 * One channel's two-bit turn-on fault code holder.
 * Assumes load, clear and code inputs come from logic on clk_sys.
 */
`timescale 1ns/1ps
module fault_code_cell
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      load,
    input  wire poe_regs_pkg::fault_code_t load_code,
    input  wire logic                      clear_off,
    input  wire logic                      clear_read,
    output poe_regs_pkg::fault_code_t      code
);
    import poe_regs_pkg::*;

    fault_code_t next_code;

    // A fault arriving with a clear is kept
    assign next_code = load                     ? load_code  :
                       (clear_off | clear_read) ? FAULT_NONE :
                                                  code;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            code <= FAULT_NONE;
        else
            code <= next_code;
    end

endmodule

// file: hw/poe_fault_and_remap_regs.sv
/*
 * Turn-on fault status and channel group remap registers for one four-channel group,
 * reached by command code through a byte-wide front end.
 * Assumes the I2C slave engine, detection, classification and power allocation logic
 * run on clk_sys; por is the power-on reset, rst the reset pin and software reset.
 */
// Functional notes
// - Record per channel why commanded turn-on failed
// - Codes: none, detection, classification, insufficient power
// - Turning channel off clears its code
// - Load cause on start fault without enable bit
// - Allocation denial reports insufficient power code
// - Dual signature four-pair channels update independently
// - Single signature four-pair channels update together
// - 24h plain read, 25h read then clear
// - Four remap fields, logical 4 in top bits
// - Code n minus one selects physical n
// - Remap permutes only inside one group
// - Remap write ignored unless group all off
// - Remap resets to identity at power-on
// - Remap survives reset pin and software reset
// - Duplicate physical codes discard the write
`timescale 1ns/1ps
module poe_fault_and_remap_regs
(
    input  wire logic                                                 clk_sys,
    input  wire logic                                                 rst,
    input  wire logic                                                 por,
    input  wire poe_regs_pkg::host_req_t                              host_req,
    output poe_regs_pkg::host_rsp_t                                   host_rsp,
    output logic                                                      remap_accepted,
    output logic                                                      remap_rejected,
    input  wire poe_regs_pkg::chan_event_t [poe_regs_pkg::GROUP_SIZE-1:0] chan_ev,
    input  wire logic [1:0]                                           four_pair,
    input  wire logic [1:0]                                           single_signature,
    input  wire logic [poe_regs_pkg::GROUP_SIZE-1:0]                  channel_power_on_command,
    output logic [poe_regs_pkg::GROUP_SIZE-1:0]                       phys_power_on,
    input  wire logic [poe_regs_pkg::GROUP_SIZE-1:0]                  phys_powered,
    output logic [poe_regs_pkg::GROUP_SIZE-1:0]                       logical_powered,
    output logic [7:0]                                                channel_group_remap,
    output logic [7:0]                                                turn_on_fault_codes
);
    import poe_regs_pkg::*;

    // ************************************************************
    // Command decode
    // ************************************************************
    wire logic sel_fault_read;
    wire logic sel_fault_clear;
    wire logic sel_remap;
    wire logic sel_any;

    assign sel_fault_read  = (host_req.cmd == CMD_FAULT_READ);
    assign sel_fault_clear = (host_req.cmd == CMD_FAULT_CLEAR);
    assign sel_remap       = (host_req.cmd == CMD_REMAP);
    assign sel_any         = sel_fault_read | sel_fault_clear | sel_remap;

    wire logic rd_clear;
    wire logic wr_remap;

    assign rd_clear = host_req.rd & sel_fault_clear;
    assign wr_remap = host_req.wr & sel_remap;

    // ************************************************************
    // Fault event shaping per channel
    // ************************************************************
    logic [GROUP_SIZE-1:0] own_load;
    fault_code_t           own_code [GROUP_SIZE];
    logic [GROUP_SIZE-1:0] cell_load;
    fault_code_t           cell_code [GROUP_SIZE];
    fault_code_t           code [GROUP_SIZE];

    genvar gi;
    generate
        for (gi = 0; gi < GROUP_SIZE; gi++)
        begin : g_chan
            localparam int PAIR = gi / 2;
            localparam int MATE = gi ^ 1;
            localparam int LOW  = PAIR * 2;
            localparam int HIGH = PAIR * 2 + 1;

            wire logic joint;

            // Only a start fault with the enable bit clear is recorded
            assign own_load[gi] = chan_ev[gi].start_fault
                                & ~chan_ev[gi].detect_classify_enable_bit;

            // Allocation denial overrides the detection or class cause
            assign own_code[gi] = chan_ev[gi].alloc_denied ? FAULT_POWER
                                                           : chan_ev[gi].cause;

            // Single signature four-pair: both channels take one outcome
            assign joint = four_pair[PAIR] & single_signature[PAIR];

            assign cell_load[gi] = own_load[gi] | (joint & own_load[MATE]);

            assign cell_code[gi] = ~joint        ? own_code[gi]   :
                                   own_load[LOW] ? own_code[LOW]  :
                                                   own_code[HIGH];

            fault_code_cell u_cell
            (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .load       (cell_load[gi]),
                .load_code  (cell_code[gi]),
                .clear_off  (chan_ev[gi].turn_off),
                .clear_read (rd_clear),
                .code       (code[gi])
            );

            // Field n at bits 2n-1:2n-2, channel 4 on top
            assign turn_on_fault_codes[gi*FIELD_W +: FIELD_W] = code[gi];
        end
    endgenerate

    // ************************************************************
    // Remap write qualification
    // ************************************************************
    wire logic group_all_off;
    wire logic dup_code;
    wire logic remap_take;
    wire logic [1:0] f0;
    wire logic [1:0] f1;
    wire logic [1:0] f2;
    wire logic [1:0] f3;

    assign f0 = host_req.wdata[1:0];
    assign f1 = host_req.wdata[3:2];
    assign f2 = host_req.wdata[5:4];
    assign f3 = host_req.wdata[7:6];

    assign group_all_off = chan_ev[0].is_off & chan_ev[1].is_off
                         & chan_ev[2].is_off & chan_ev[3].is_off;

    assign dup_code = (f0 == f1) | (f0 == f2) | (f0 == f3)
                    | (f1 == f2) | (f1 == f3) | (f2 == f3);

    assign remap_take = wr_remap & group_all_off & ~dup_code;

    // ************************************************************
    // Remap register, reset to identity by power-on only
    // ************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (por)
            channel_group_remap <= REMAP_RESET;
        else if (remap_take)
            channel_group_remap <= host_req.wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst | por)
        begin
            remap_accepted <= 1'b0;
            remap_rejected <= 1'b0;
        end
        else
        begin
            remap_accepted <= remap_take;
            remap_rejected <= wr_remap & ~remap_take;
        end
    end

    // ************************************************************
    // Channel routing inside the group
    // ************************************************************
    logic [GROUP_SIZE-1:0] next_phys_power_on;
    logic [GROUP_SIZE-1:0] next_logical_powered;
    logic [1:0]            phys_idx;

    // Routing never leaves the four channels of this group
    always_comb
    begin
        next_phys_power_on   = '0;
        next_logical_powered = '0;
        phys_idx             = 2'h0;
        for (int i = 0; i < GROUP_SIZE; i++)
        begin
            phys_idx = channel_group_remap[i*FIELD_W +: FIELD_W];
            next_phys_power_on[phys_idx] = channel_power_on_command[i];
            next_logical_powered[i]      = phys_powered[phys_idx];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst | por)
        begin
            phys_power_on   <= '0;
            logical_powered <= '0;
        end
        else
        begin
            phys_power_on   <= next_phys_power_on;
            logical_powered <= next_logical_powered;
        end
    end

    // ************************************************************
    // Read response
    // ************************************************************
    wire logic [7:0] rd_mux;

    assign rd_mux = (sel_fault_read | sel_fault_clear) ? turn_on_fault_codes :
                    sel_remap                          ? channel_group_remap :
                                                         UNMAPPED_VAL;

    always_ff @(posedge clk_sys)
    begin
        if (rst | por)
            host_rsp <= '{valid: 1'b0, hit: 1'b0, data: FAULT_RESET};
        else
        begin
            host_rsp.valid <= host_req.rd;
            host_rsp.hit   <= host_req.rd & sel_any;
            host_rsp.data  <= host_req.rd ? rd_mux : host_rsp.data;
        end
    end

endmodule

// file: hw/poe_regs_pkg.sv
/*
 * Shared constants and carrier types for the turn-on fault and channel remap register bank.
 * Assumes a byte-wide command front end (I2C slave engine) on the same clock.
 */
package poe_regs_pkg;

    // ************************************************************
    // Group geometry
    // ************************************************************
    localparam int GROUP_SIZE = 4;
    localparam int FIELD_W    = 2;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_FAULT_READ  = 8'h24;
    localparam logic [7:0] CMD_FAULT_CLEAR = 8'h25;
    localparam logic [7:0] CMD_REMAP       = 8'h26;

    // ************************************************************
    // Values after reset and for unmapped reads
    // ************************************************************
    localparam logic [7:0] REMAP_RESET  = 8'hE4;
    localparam logic [7:0] FAULT_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        FAULT_NONE   = 2'h0,
        FAULT_DETECT = 2'h1,
        FAULT_CLASS  = 2'h2,
        FAULT_POWER  = 2'h3
    } fault_code_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [7:0] data;
    } host_rsp_t;

    typedef struct packed {
        logic        start_fault;
        fault_code_t cause;
        logic        detect_classify_enable_bit;
        logic        alloc_denied;
        logic        turn_off;
        logic        is_off;
    } chan_event_t;

endpackage

// file: sim/host_model.sv
/* Host stand-in issuing single-byte command transfers. Assumes answers one cycle later. */
`timescale 1ns/1ps
module host_model
(
    input  wire logic                    clk_sys,
    output poe_regs_pkg::host_req_t      host_req,
    input  wire poe_regs_pkg::host_rsp_t host_rsp
);
    import poe_regs_pkg::*;
    initial host_req = '0;
    // One byte per command code, never a burst
    task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [7:0] wd,
        output logic [9:0] got);
        @(posedge clk_sys);
        host_req <= '{rd: rd, wr: !rd, cmd: cmd, wdata: wd};
        @(posedge clk_sys);
        host_req <= '0;
        #1 got = {host_rsp.valid, host_rsp.hit, host_rsp.data};
    endtask
endmodule

// file: sim/poe_regs_props.sv
/* Port assertions for the fault and remap bank. Assumes one clk_sys domain. */
`timescale 1ns/1ps
module poe_regs_props
(
    input wire logic                      clk_sys,
    input wire logic                      rst,
    input wire logic                      por,
    input wire poe_regs_pkg::host_req_t   host_req,
    input wire poe_regs_pkg::host_rsp_t   host_rsp,
    input wire logic                      remap_accepted,
    input wire logic                      remap_rejected,
    input wire poe_regs_pkg::chan_event_t [poe_regs_pkg::GROUP_SIZE-1:0] chan_ev,
    input wire logic [7:0]                channel_group_remap,
    input wire logic [7:0]                turn_on_fault_codes
);
    import poe_regs_pkg::*;
    wire [7:0] w = host_req.wdata;
    wire dup = w[1:0] == w[3:2] || w[1:0] == w[5:4] || w[1:0] == w[7:6]
        || w[3:2] == w[5:4] || w[3:2] == w[7:6] || w[5:4] == w[7:6];
    wire all_off = chan_ev[0].is_off && chan_ev[1].is_off && chan_ev[2].is_off
        && chan_ev[3].is_off;
    wire no_sf = !(chan_ev[0].start_fault || chan_ev[1].start_fault
        || chan_ev[2].start_fault || chan_ev[3].start_fault);
    wire quiet = no_sf && !(chan_ev[0].turn_off || chan_ev[1].turn_off
        || chan_ev[2].turn_off || chan_ev[3].turn_off);
    wire rm_wr = host_req.wr && host_req.cmd == CMD_REMAP;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || por);

    a_rsp_valid: assert property (host_req.rd |=> host_rsp.valid)
        else $error("read got no answer");
    a_keep_read: assert property (host_req.rd && host_req.cmd == CMD_FAULT_READ && quiet |=>
        host_rsp.data == $past(turn_on_fault_codes) && $stable(turn_on_fault_codes))
        else $error("plain read changed or misreported faults");
    a_clear_read: assert property (host_req.rd && host_req.cmd == CMD_FAULT_CLEAR && no_sf
        |=> turn_on_fault_codes == 8'h00)
        else $error("clearing read left faults");
    a_power_code: assert property (chan_ev[3].start_fault && chan_ev[3].alloc_denied
        && !chan_ev[3].detect_classify_enable_bit && !chan_ev[2].start_fault
        |=> turn_on_fault_codes[7:6] == 2'h3)
        else $error("denied power not coded 3");
    a_remap_take: assert property (rm_wr && all_off && !dup |=> remap_accepted
        && channel_group_remap == $past(host_req.wdata))
        else $error("good remap write not taken");
    a_remap_busy: assert property (rm_wr && !all_off |=>
        remap_rejected && $stable(channel_group_remap))
        else $error("remap taken with channel on");
    a_remap_dup: assert property (rm_wr && dup |=>
        remap_rejected && $stable(channel_group_remap))
        else $error("duplicate remap taken");
    a_por_ident: assert property (disable iff (1'b0) por |=> channel_group_remap == 8'hE4)
        else $error("power-on remap not identity");
    a_rst_keep: assert property (disable iff (por) rst && !host_req.wr |=>
        $stable(channel_group_remap))
        else $error("reset pin altered remap");

    c_take: cover property (remap_accepted);
    c_refuse: cover property (remap_rejected);
    c_clear: cover property (host_req.rd && host_req.cmd == CMD_FAULT_CLEAR);
endmodule

bind poe_fault_and_remap_regs poe_regs_props u_props (.clk_sys, .rst, .por, .host_req,
    .host_rsp, .remap_accepted, .remap_rejected, .chan_ev, .channel_group_remap,
    .turn_on_fault_codes);

// file: sim/tb_top.sv
/* Self-checking bench for the fault and remap bank. Assumes host_model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    import poe_regs_pkg::*;
    logic              clk_sys = 0;
    logic              rst = 1;
    logic              por = 1;
    host_req_t         host_req;
    host_rsp_t         host_rsp;
    logic              acc;
    logic              rej;
    chan_event_t [3:0] ev;
    logic [1:0]        four_pair = 0;
    logic [1:0]        single_sig = 0;
    logic [3:0]        cmd_on = 0;
    logic [3:0]        phys_pw = 0;
    logic [3:0]        phys_on;
    logic [3:0]        log_pw;
    logic [7:0]        remap;
    logic [7:0]        faults;
    logic [9:0]        got;
    int                err_count = 0;
    int                tests_run = 0;
    always #50 clk_sys = ~clk_sys;
    host_model host (.clk_sys(clk_sys), .host_req(host_req), .host_rsp(host_rsp));
    poe_fault_and_remap_regs DUT (.clk_sys(clk_sys), .rst(rst), .por(por),
        .host_req(host_req), .host_rsp(host_rsp), .remap_accepted(acc),
        .remap_rejected(rej), .chan_ev(ev), .four_pair(four_pair),
        .single_signature(single_sig), .channel_power_on_command(cmd_on),
        .phys_power_on(phys_on), .phys_powered(phys_pw), .logical_powered(log_pw),
        .channel_group_remap(remap), .turn_on_fault_codes(faults));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fault(input int ch, input fault_code_t c, input logic en, input logic den);
        @(posedge clk_sys);
        ev[ch].start_fault <= 1;
        ev[ch].cause <= c;
        ev[ch].detect_classify_enable_bit <= en;
        ev[ch].alloc_denied <= den;
        @(posedge clk_sys);
        ev[ch].start_fault <= 0;
        #1;
    endtask
    task automatic t_faults();
        fault(0, FAULT_DETECT, 0, 0);
        fault(1, FAULT_CLASS, 0, 0);
        fault(2, FAULT_POWER, 0, 0);
        fault(3, FAULT_DETECT, 0, 0);
        chk("codes", 8'h79, faults);
        fault(3, FAULT_CLASS, 1, 0);
        chk("enabled", 8'h79, faults);
        fault(3, FAULT_DETECT, 0, 1);
        chk("denied", 8'hF9, faults);
        host.xfer(1, CMD_FAULT_READ, 0, got);
        chk("plain data", 8'hF9, got[7:0]);
        chk("plain flags", 8'h03, {6'h0, got[9:8]});
        chk("plain kept", 8'hF9, faults);
        host.xfer(1, CMD_FAULT_CLEAR, 0, got);
        chk("clear data", 8'hF9, got[7:0]);
        chk("cleared", 8'h00, faults);
        host.xfer(1, 8'h30, 0, got);
        chk("unmapped flags", 8'h02, {6'h0, got[9:8]});
        chk("unmapped data", 8'h00, got[7:0]);
        fault(1, FAULT_CLASS, 0, 0);
        chk("class again", 8'h08, faults);
        @(posedge clk_sys);
        ev[1].turn_off <= 1;
        @(posedge clk_sys);
        ev[1].turn_off <= 0;
        #1 chk("off clear", 8'h00, faults);
        $display("t_faults done");
    endtask
    task automatic t_pair();
        @(posedge clk_sys);
        four_pair <= 2'b01;
        single_sig <= 2'b01;
        fault(0, FAULT_CLASS, 0, 0);
        chk("single pair", 8'h0A, faults);
        host.xfer(1, CMD_FAULT_CLEAR, 0, got);
        @(posedge clk_sys);
        single_sig <= 2'b00;
        fault(0, FAULT_CLASS, 0, 0);
        chk("dual pair", 8'h02, faults);
        host.xfer(1, CMD_FAULT_CLEAR, 0, got);
        $display("t_pair done");
    endtask
    task automatic t_remap();
        host.xfer(0, CMD_REMAP, 8'h1B, got);
        chk("take", 8'h1B, remap);
        chk("take pulse", 8'h01, {7'h0, acc});
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            cmd_on <= 4'(1 << i);
            phys_pw <= 4'(8 >> i);
            repeat (2) @(posedge clk_sys);
            #1 chk("route out", 8'(8 >> i), 8'(phys_on));
            chk("route back", 8'(1 << i), 8'(log_pw));
        end
        host.xfer(0, CMD_REMAP, 8'h1A, got);
        chk("dup pulse", 8'h01, {7'h0, rej});
        @(posedge clk_sys);
        ev[2].is_off <= 0;
        host.xfer(0, CMD_REMAP, 8'hE4, got);
        chk("busy pulse", 8'h01, {7'h0, rej});
        @(posedge clk_sys);
        ev[2].is_off <= 1;
        host.xfer(1, CMD_REMAP, 0, got);
        chk("remap read", 8'h1B, got[7:0]);
        chk("remap flags", 8'h03, {6'h0, got[9:8]});
        @(posedge clk_sys);
        rst <= 1;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        #1 chk("rst keeps", 8'h1B, remap);
        @(posedge clk_sys);
        por <= 1;
        repeat (2) @(posedge clk_sys);
        por <= 0;
        #1 chk("por ident", REMAP_RESET, remap);
        $display("t_remap done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_count++;
        finish_test();
    end
    initial
    begin
        ev = '0;
        for (int i = 0; i < 4; i++)
            ev[i].is_off = 1;
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        por <= 0;
        @(posedge clk_sys);
        #1 chk("reset remap", REMAP_RESET, remap);
        chk("reset faults", FAULT_RESET, faults);
        t_faults();
        t_pair();
        t_remap();
        finish_test();
    end
endmodule
